//--- pkg/frwg_pkg.sv
// Shared constants, command codes, carriers and state codes for the flash block read-while-write guard.
// Assumes one 10 MHz system clock and word addressing of the flash array.
`default_nettype none

package frwg_pkg;

    // Timing
    localparam int FRWG_CLK_NS      = 100;
    localparam int FRWG_ERASE_NS    = 2000;
    localparam int FRWG_PROG_NS     = 450;
    // Least times, so they round up to whole cycles
    localparam int FRWG_ERASE_CYC   = (FRWG_ERASE_NS + FRWG_CLK_NS - 1) / FRWG_CLK_NS;
    localparam int FRWG_PROG_CYC    = (FRWG_PROG_NS + FRWG_CLK_NS - 1) / FRWG_CLK_NS;
    localparam int FRWG_CNT_W       = 16;

    // Widths
    localparam int FRWG_AW          = 16;
    localparam int FRWG_DW          = 32;

    // Command codes held in the command object
    localparam logic [7:0] FRWG_CMD_PROG  = 8'h06;
    localparam logic [7:0] FRWG_CMD_ERASE = 8'h09;

    // Values after reset
    localparam logic            FRWG_CCF_RST   = 1'b1;
    localparam logic            FRWG_FLAG_RST  = 1'b0;
    localparam logic [FRWG_DW-1:0] FRWG_ERASED = 32'hFFFF_FFFF;

    typedef struct packed {
        logic [7:0]         code;
        logic [FRWG_AW-1:0] addr;
        logic [FRWG_DW-1:0] data;
    } frwg_cobj_t;

    typedef struct packed {
        logic               req;
        logic               fetch;
        logic [FRWG_AW-1:0] addr;
    } frwg_rd_t;

    typedef enum logic [2:0] {
        FRWG_IDLE  = 3'b001,
        FRWG_ERASE = 3'b010,
        FRWG_PROG  = 3'b100
    } frwg_state_t;

endpackage

`default_nettype wire

//--- hdl/frwg_bank.sv
// One flash block: its own storage, erase sequencer and program sequencer.
// Assumes start is a one-cycle request that only arrives while the block is idle.
`default_nettype none

module frwg_bank
    import frwg_pkg::*;
#(
    parameter int WORDS      = 16,
    parameter int SECT_WORDS = 4,
    parameter int DW         = FRWG_DW,
    parameter int IW         = $clog2(WORDS)
)(
    // System
    input  wire logic          clk,
    input  wire logic          rst,
    input  wire logic          ce,
    // Operation request
    input  wire logic          start,
    input  wire logic          erase,
    input  wire logic [IW-1:0] widx,
    input  wire logic [DW-1:0] wdata,
    // Read port
    input  wire logic [IW-1:0] ridx,
    output logic      [DW-1:0] rdata,
    // Status
    output logic               busy,
    output logic               done
);

    localparam int SB     = $clog2(SECT_WORDS);
    localparam int E_WAIT = FRWG_ERASE_CYC + 1;
    localparam int P_WAIT = FRWG_PROG_CYC + 1;
    localparam int P_LEFT = P_WAIT - 1;

    frwg_state_t           st_r,   st_nxt;
    logic [FRWG_CNT_W-1:0] cnt_r,  cnt_nxt;
    logic [IW-1:0]         idx_r,  idx_nxt;
    logic [DW-1:0]         dat_r,  dat_nxt;
    logic [DW-1:0]         mem_r   [WORDS];
    logic [DW-1:0]         mem_nxt [WORDS];
    logic                  busy_r, busy_nxt;
    logic                  done_r, done_nxt;

    // Reads see the array directly; the top decides whether the answer is legal
    assign rdata = mem_r[ridx];
    assign busy  = busy_r;
    assign done  = done_r;

    always_comb
    begin
        st_nxt   = st_r;
        cnt_nxt  = cnt_r;
        idx_nxt  = idx_r;
        dat_nxt  = dat_r;
        mem_nxt  = mem_r;
        done_nxt = 1'b0;
        case (st_r)
            FRWG_IDLE:
            begin
                if (start)
                begin
                    st_nxt  = erase ? FRWG_ERASE : FRWG_PROG;
                    cnt_nxt = erase ? FRWG_CNT_W'(FRWG_ERASE_CYC - 1) : FRWG_CNT_W'(FRWG_PROG_CYC - 1);
                    idx_nxt = widx;
                    dat_nxt = wdata;
                end
            end
            FRWG_ERASE:
            begin
                if (cnt_r == '0)
                begin
                    // Sector erase: only words sharing the upper index bits
                    for (int i = 0; i < WORDS; i++)
                        if (IW'(i) >> SB == idx_r >> SB)
                            mem_nxt[i] = FRWG_ERASED[DW-1:0];
                    st_nxt   = FRWG_IDLE;
                    done_nxt = 1'b1;
                end
                else
                    cnt_nxt = cnt_r - 1'b1;
            end
            FRWG_PROG:
            begin
                if (cnt_r == '0)
                begin
                    // Programming can only clear bits, as in real flash cells
                    mem_nxt[idx_r] = mem_r[idx_r] & dat_r;
                    st_nxt   = FRWG_IDLE;
                    done_nxt = 1'b1;
                end
                else
                    cnt_nxt = cnt_r - 1'b1;
            end
            default:
                st_nxt = FRWG_IDLE;
        endcase
        busy_nxt = (st_nxt != FRWG_IDLE);
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            st_r   <= FRWG_IDLE;
            cnt_r  <= '0;
            idx_r  <= '0;
            dat_r  <= '0;
            busy_r <= 1'b0;
            done_r <= 1'b0;
            for (int i = 0; i < WORDS; i++)
                mem_r[i] <= FRWG_ERASED[DW-1:0];
        end
        else if (ce)
        begin
            st_r    <= st_nxt;
            cnt_r   <= cnt_nxt;
            idx_r   <= idx_nxt;
            dat_r   <= dat_nxt;
            busy_r  <= busy_nxt;
            done_r  <= done_nxt;
            mem_r   <= mem_nxt;
        end
    end

    erase_time_a: assert property (@(posedge clk) disable iff (rst || !ce)
        start && erase && !busy |-> ##[E_WAIT:E_WAIT] done)
        else $error("erase did not finish on time");

    prog_time_a: assert property (@(posedge clk) disable iff (rst || !ce)
        start && !erase && !busy |-> ##1 busy ##[P_LEFT:P_LEFT] done && !busy)
        else $error("program did not finish on time");

endmodule

`default_nettype wire

//--- hdl/frwg_top.sv
// Flash read-while-write guard: command launch, per-block sequencers and read collision detection.
// Assumes requests come from logic on clk, block address ranges do not overlap, addresses are word indices.
`default_nettype none

module frwg_top
    import frwg_pkg::*;
#(
    parameter int NBLK       = 2,
    parameter int BLK_WORDS  = 16,
    parameter int SECT_WORDS = 4,
    parameter logic [NBLK-1:0][FRWG_AW-1:0] BLK_BASE = {16'h0010, 16'h0000}
)(
    // System
    input  wire logic               clk,
    input  wire logic               rst,
    input  wire logic               ce,
    // Command object load and launch
    input  wire logic               cobj_we,
    input  wire frwg_cobj_t         cobj,
    input  wire logic               ccf_clr,
    // Read and fetch port
    input  wire frwg_rd_t           rd,
    // Collision flag clear
    input  wire logic               coll_clr,
    // Status
    output logic                    command_complete_flag,
    output logic                    cmd_access_err,
    output logic                    read_collision,
    output logic [NBLK-1:0]         blk_busy,
    // Read answer
    output logic                    rd_valid,
    output logic                    rd_err,
    output logic [FRWG_DW-1:0]      rd_data
);

    localparam int IW = $clog2(BLK_WORDS);

    frwg_cobj_t            cobj_r, cobj_nxt;
    logic                  ccf_r,  ccf_nxt;
    logic                  acc_r,  acc_nxt;
    logic                  coll_r, coll_nxt;
    logic                  rdv_r,  rdv_nxt;
    logic                  rde_r,  rde_nxt;
    logic [FRWG_DW-1:0]    rdd_r,  rdd_nxt;

    logic [NBLK-1:0]               rd_hit;
    logic [NBLK-1:0]               cmd_hit;
    logic [NBLK-1:0]               start;
    logic [NBLK-1:0]               busy;
    logic [NBLK-1:0]               done;
    logic [NBLK-1:0][IW-1:0]       rd_idx;
    logic [NBLK-1:0][IW-1:0]       cmd_idx;
    logic [NBLK-1:0][FRWG_DW-1:0]  bank_data;
    logic                          cmd_ok;
    logic                          rd_busy_hit;

    // Address decode per block from the base and size parameters
    always_comb
    begin
        rd_hit  = '0;
        cmd_hit = '0;
        rd_idx  = '0;
        cmd_idx = '0;
        for (int i = 0; i < NBLK; i++)
        begin
            rd_hit[i]  = (rd.addr >= BLK_BASE[i]) && (rd.addr - BLK_BASE[i] < FRWG_AW'(BLK_WORDS));
            cmd_hit[i] = (cobj_r.addr >= BLK_BASE[i]) && (cobj_r.addr - BLK_BASE[i] < FRWG_AW'(BLK_WORDS));
            rd_idx[i]  = IW'(rd.addr - BLK_BASE[i]);
            cmd_idx[i] = IW'(cobj_r.addr - BLK_BASE[i]);
        end
    end

    genvar g;
    generate
        for (g = 0; g < NBLK; g++)
        begin : blk
            // Each block sequences alone, so one busy block never stalls reads of another
            frwg_bank #(
                .WORDS      (BLK_WORDS),
                .SECT_WORDS (SECT_WORDS),
                .DW         (FRWG_DW),
                .IW         (IW)
            ) u_bank (
                .clk   (clk),
                .rst   (rst),
                .ce    (ce),
                .start (start[g]),
                .erase (cobj_r.code == FRWG_CMD_ERASE),
                .widx  (cmd_idx[g]),
                .wdata (cobj_r.data),
                .ridx  (rd_idx[g]),
                .rdata (bank_data[g]),
                .busy  (busy[g]),
                .done  (done[g])
            );
        end
    endgenerate

    // Command launch and completion
    always_comb
    begin
        cobj_nxt = cobj_r;
        ccf_nxt  = ccf_r;
        acc_nxt  = acc_r;
        start    = '0;
        cmd_ok   = ((cobj_r.code == FRWG_CMD_ERASE) || (cobj_r.code == FRWG_CMD_PROG)) && (|cmd_hit);
        // Loads during a running command are dropped so the parameters stay stable
        if (cobj_we && ccf_r)
            cobj_nxt = cobj;
        if (ccf_r && ccf_clr)
        begin
            if (cmd_ok)
            begin
                start   = cmd_hit;
                ccf_nxt = 1'b0;
                acc_nxt = 1'b0;
            end
            else
                acc_nxt = 1'b1;
        end
        if (|done)
            ccf_nxt = 1'b1;
    end

    // Read path and collision flag
    always_comb
    begin
        rd_busy_hit = |(rd_hit & busy);
        rdv_nxt     = rd.req;
        // Fetch and data reads take the same path on purpose
        rde_nxt     = rd.req && (rd_busy_hit || !(|rd_hit));
        rdd_nxt     = FRWG_ERASED;
        if (rd.req && !rd_busy_hit)
        begin
            for (int i = 0; i < NBLK; i++)
                if (rd_hit[i])
                    rdd_nxt = bank_data[i];
        end
        coll_nxt = coll_r;
        if (coll_clr)
            coll_nxt = 1'b0;
        // Set wins over a clear in the same cycle
        if (rd.req && rd_busy_hit)
            coll_nxt = 1'b1;
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            cobj_r <= '0;
            ccf_r  <= FRWG_CCF_RST;
            acc_r  <= FRWG_FLAG_RST;
            coll_r <= FRWG_FLAG_RST;
            rdv_r  <= 1'b0;
            rde_r  <= 1'b0;
            rdd_r  <= '0;
        end
        else if (ce)
        begin
            cobj_r <= cobj_nxt;
            ccf_r  <= ccf_nxt;
            acc_r  <= acc_nxt;
            coll_r <= coll_nxt;
            rdv_r  <= rdv_nxt;
            rde_r  <= rde_nxt;
            rdd_r  <= rdd_nxt;
        end
    end

    assign command_complete_flag = ccf_r;
    assign cmd_access_err        = acc_r;
    assign read_collision        = coll_r;
    assign blk_busy              = busy;
    assign rd_valid              = rdv_r;
    assign rd_err                = rde_r;
    assign rd_data               = rdd_r;

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst || !ce);

    sequence launch_s;
        ccf_r && ccf_clr && cmd_ok;
    endsequence

    sequence running_s;
        (!ccf_r && (|busy)) [*2];
    endsequence

    coll_set_a: assert property (rd.req && rd_busy_hit |=> read_collision && rd_valid && rd_err)
        else $error("busy block read did not raise collision");

    fetch_coll_a: assert property (rd.req && rd.fetch && (|(rd_hit & busy)) |=> read_collision)
        else $error("fetch from busy block not flagged");

    idle_read_a: assert property (rd.req && (|rd_hit) && !(|(rd_hit & busy)) |=> rd_valid && !rd_err)
        else $error("read of idle block refused");

    no_spur_coll_a: assert property (!read_collision && !(rd.req && (|(rd_hit & busy))) |=> !read_collision)
        else $error("collision flag set without cause");

    launch_run_a: assert property (launch_s |=> running_s)
        else $error("launch did not start command");

    load_hold_a: assert property (!ccf_r |=> $stable(cobj_r))
        else $error("command object changed while running");

    done_flag_a: assert property (|done |=> command_complete_flag)
        else $error("complete flag not set after finish");

    coll_stick_a: assert property (read_collision && !coll_clr |=> read_collision)
        else $error("collision flag dropped without clear");

    coll_clear_a: assert property (read_collision && coll_clr && !(rd.req && rd_busy_hit) |=> !read_collision)
        else $error("collision flag clear ignored");

endmodule

`default_nettype wire

//--- testbench/frwg_core_mdl.sv
// Processor core model: loads the command object, launches, reads and fetches.
// Assumes the bench calls its tasks one at a time; signals change only at rising edges.
`default_nettype none

module frwg_core_mdl
    import frwg_pkg::*;
(
    // System
    input  wire logic   clk,
    // Command object and launch
    output var logic       cobj_we,
    output var frwg_cobj_t cobj,
    output var logic       ccf_clr,
    // Reads and fetches
    output var frwg_rd_t   rd
);
    timeunit 1ns;
    timeprecision 1ns;

    time t_launch;

    initial
    begin
        cobj_we  = 1'b0;
        cobj     = '0;
        ccf_clr  = 1'b0;
        rd       = '0;
        t_launch = 0;
    end

    // Object goes in a full cycle before the launch edge
    task automatic launch(input logic [7:0] code, input logic [15:0] addr, input logic [31:0] data);
        @(posedge clk);
        cobj_we <= 1'b1;
        cobj    <= '{code, addr, data};
        @(posedge clk);
        cobj_we <= 1'b0;
        cobj    <= '{~code, ~addr, ~data};
        ccf_clr <= 1'b1;
        @(posedge clk);
        ccf_clr  <= 1'b0;
        t_launch = $time;
    endtask

    // Released address lines show the inverse, never the old value
    task automatic read(input logic fetch, input logic [15:0] addr);
        @(posedge clk);
        rd <= '{1'b1, fetch, addr};
        @(posedge clk);
        rd <= '{1'b0, 1'b0, ~addr};
    endtask
endmodule

`default_nettype wire

//--- testbench/frwg_top_tb.sv
// Self-checking bench of the read-while-write guard with two blocks.
// Assumes the default block map: block 0 at 0x0000, block 1 at 0x0010, 16 words each.
`default_nettype none

module frwg_top_tb
    import frwg_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;

    logic              clk;
    logic              rst;
    logic              ce;
    logic              cobj_we;
    frwg_cobj_t        cobj;
    logic              ccf_clr;
    frwg_rd_t          rd;
    logic              coll_clr;
    logic              flag;
    logic              acc_err;
    logic              coll;
    logic [1:0]        busy;
    logic              rd_valid;
    logic              rd_err;
    logic [31:0]       rd_data;
    int                n_fail;
    int                check_count;
    int                cyc;

    frwg_core_mdl frwg_core_mdl_inst (.clk(clk), .cobj_we(cobj_we), .cobj(cobj), .ccf_clr(ccf_clr), .rd(rd));

    frwg_top frwg_top_inst (
        .clk(clk), .rst(rst), .ce(ce), .cobj_we(cobj_we), .cobj(cobj), .ccf_clr(ccf_clr),
        .rd(rd), .coll_clr(coll_clr), .command_complete_flag(flag), .cmd_access_err(acc_err),
        .read_collision(coll), .blk_busy(busy), .rd_valid(rd_valid), .rd_err(rd_err), .rd_data(rd_data)
    );

    initial
    begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask

    task automatic report_and_stop();
        $display("checks=%0d mismatches=%0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // Hang guard: whole run needs well under a thousand cycles
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 5000)
        begin
            n_fail++;
            report_and_stop();
        end
    end

    task automatic do_read(input logic fetch, input logic [15:0] addr, input logic err, input logic [31:0] exp);
        frwg_core_mdl_inst.read(fetch, addr);
        #1;
        check(rd_valid, 1'b1);
        check(rd_err, err);
        check(rd_data, exp);
    endtask

    // Edges from the launch edge to the first edge that shows the flag set
    task automatic wait_done(input int exp_edges);
        int n;
        for (n = 0; n < 100; n++)
        begin
            @(posedge clk);
            #1;
            if (flag === 1'b1)
                break;
        end
        check(32'(($time - 1 - frwg_core_mdl_inst.t_launch) / 100), 32'(exp_edges));
    endtask

    task automatic t_reset_state();
        check(flag, FRWG_CCF_RST);
        check(coll, 1'b0);
        check(busy, 2'b00);
        do_read(1'b0, 16'h0003, 1'b0, FRWG_ERASED);
    endtask

    task automatic t_program();
        frwg_core_mdl_inst.launch(FRWG_CMD_PROG, 16'h0003, 32'h1234_5678);
        #1;
        check(flag, 1'b0);
        check(busy, 2'b01);
        wait_done(FRWG_PROG_CYC + 1);
        check(busy, 2'b00);
        do_read(1'b0, 16'h0003, 1'b0, 32'h1234_5678);
        frwg_core_mdl_inst.launch(FRWG_CMD_PROG, 16'h0011, 32'h0000_00A5);
        wait_done(FRWG_PROG_CYC + 1);
        frwg_core_mdl_inst.launch(FRWG_CMD_PROG, 16'h0015, 32'h0000_005A);
        wait_done(FRWG_PROG_CYC + 1);
    endtask

    task automatic t_erase_collide();
        frwg_core_mdl_inst.launch(FRWG_CMD_ERASE, 16'h0012, 32'h0);
        #1;
        check(busy, 2'b10);
        do_read(1'b1, 16'h0003, 1'b0, 32'h1234_5678);
        check(coll, 1'b0);
        do_read(1'b0, 16'h0015, 1'b1, FRWG_ERASED);
        check(coll, 1'b1);
        repeat (2) @(posedge clk);
        #1;
        check(coll, 1'b1);
        @(posedge clk);
        coll_clr <= 1'b1;
        @(posedge clk);
        coll_clr <= 1'b0;
        #1;
        check(coll, 1'b0);
        do_read(1'b1, 16'h001F, 1'b1, FRWG_ERASED);
        check(coll, 1'b1);
        wait_done(FRWG_ERASE_CYC + 1);
        do_read(1'b0, 16'h0011, 1'b0, FRWG_ERASED);
        do_read(1'b0, 16'h0015, 1'b0, 32'h0000_005A);
        check(coll, 1'b1);
    endtask

    task automatic t_bad_code();
        frwg_core_mdl_inst.launch(8'h00, 16'h0004, 32'h0);
        #1;
        check(acc_err, 1'b1);
        check(flag, 1'b1);
        check(busy, 2'b00);
    endtask

    // Frozen edges stretch the count by exactly as many cycles
    task automatic t_freeze();
        frwg_core_mdl_inst.launch(FRWG_CMD_PROG, 16'h0016, 32'h0000_000F);
        ce <= 1'b0;
        repeat (3) @(posedge clk);
        ce <= 1'b1;
        #1;
        check(busy, 2'b10);
        check(flag, 1'b0);
        check(acc_err, 1'b0);
        wait_done(FRWG_PROG_CYC + 4);
        do_read(1'b0, 16'h0016, 1'b0, 32'h0000_000F);
        do_read(1'b0, 16'h0040, 1'b1, FRWG_ERASED);
    endtask

    initial
    begin
        n_fail      = 0;
        check_count = 0;
        cyc         = 0;
        coll_clr    = 1'b0;
        ce          = 1'b1;
        rst         = 1'b1;
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        #1;
        t_reset_state();
        t_program();
        t_erase_collide();
        t_bad_code();
        t_freeze();
        report_and_stop();
    end
endmodule

`default_nettype wire
